// [src/dtw_pkg.sv]
// Purpose: Shared constants and types for the dual 8-bit timer block
// Assumes: APB slave, 32-bit data, one word per register
// Notes: Printed offsets are indices; byte address is index times four
`default_nettype none
package dtw_pkg;
    // Register indices as printed
    localparam logic [9:0] IDX_IRQ_FLAGS = 10'h002;
    localparam logic [9:0] IDX_PORT_A_MODE = 10'h004;
    localparam logic [9:0] IDX_T1_MODE = 10'h009;
    localparam logic [9:0] IDX_T1_LOAD_LO = 10'h00A;
    localparam logic [9:0] IDX_T1_LOAD_HI = 10'h00B;
    localparam logic [9:0] IDX_T2_MODE = 10'h00D;
    localparam logic [9:0] IDX_T2_LOAD_LO = 10'h00E;
    localparam logic [9:0] IDX_T2_LOAD_HI = 10'h00F;
    localparam logic [9:0] IDX_MISC = 10'h020;
    localparam logic [9:0] IDX_PIN_SEL = 10'h024;
    localparam logic [9:0] IDX_EDGE_SEL = 10'h026;
    // Field positions
    localparam int T1_IRQ_BIT = 0;
    localparam int T2_IRQ_BIT = 2;
    localparam int WDOG_ON_BIT = 1;
    localparam int TOUT_EN_BIT = 2;
    localparam int MODE_RELOAD_BIT = 3;
    // Reset values and counter overflow value
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [1:0] EDGE_RST = 2'h0;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    // Mode change delay: two instruction cycles, one clock each
    localparam int MODE_DELAY_INSTR = 2;
    localparam int CLK_PER_INSTR = 1;
    localparam logic [1:0] MODE_DELAY_CYC =
        2'(MODE_DELAY_INSTR * CLK_PER_INSTR);
    // External event input is the eighth first-timer clock choice
    localparam logic [2:0] SRC_EVENT = 3'h7;
    localparam int PRESC_W = 11;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } dtw_byte_type;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH = 2'b10,
        EDGE_NONE = 2'b11
    } dtw_edge_type;
endpackage : dtw_pkg
`default_nettype wire

// [src/dtw_timers.sv]
// Purpose: Two 8-bit timers, watchdog and pulse output behind APB
// Assumes: 20 MHz i_clk, synchronous active-high reset, one wait state
// Notes: Count registers answer reads; load registers take writes
//
// Function
// - Edge-select register, two bits, write only, clears to zero on reset.
// - First timer load low nibble resets to zero; high nibble undefined.
// - Writing load low nibble only stores it; counter unchanged.
// - Writing load high nibble loads counter with full eight-bit value.
// - High-only write reloads counter using the retained low nibble.
// - Reading count high returns high nibble and latches low nibble.
// - Later low read returns the latched nibble, forming coherent count.
// - Event pin select register is write only, reset to zero.
// - Second timer mode: four bits, reload flag plus prescaler choice.
// - New second timer mode takes effect two instruction cycles later.
// - Second timer counts up, overflows at FF, reloads or restarts.
// - Second timer overflow sets sticky flag, cleared by software or reset.
// - Watchdog on: any second timer overflow requests a full reset.
// - Timer output drives pin only when enabled; resets to zero.
// - Pulse output duty and period follow mode and load value.
// - Second timer load and read registers follow the same protocol.
// - First timer counts up, overflows past FF, reloads or restarts.
// - First timer overflow sets sticky flag, cleared by software or reset.
//
// The APB slave port is this design's own decision.
`default_nettype none
module dtw_timers
    import dtw_pkg::*;
#(
    // Taps are fixed bits, so the divider cannot be narrower
    parameter int PRESC_BITS = PRESC_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_event_input_pin,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_watchdog_reset_req,
    output logic o_timer_pulse_output_pin,
    output logic o_timer_pulse_output_oe_n,
    output logic o_first_timer_irq_flag,
    output logic o_second_timer_irq_flag
);
    logic [2:0] evt_sync_ff;
    logic evt_level_ff;
    logic [PRESC_BITS-1:0] presc_ff;
    logic [3:0] t1_mode_ff;
    logic [1:0] first_timer_edge_select_ff;
    logic [3:0] event_pin_select_ff;
    dtw_byte_type t1_load_ff;
    logic [7:0] first_timer_counter_ff;
    logic [3:0] t1_latch_ff;
    logic [3:0] second_timer_mode_ff;
    logic [3:0] t2_mode_pend_ff;
    logic [1:0] t2_mode_dly_ff;
    dtw_byte_type t2_load_ff;
    logic [7:0] second_timer_counter_ff;
    logic [3:0] t2_latch_ff;
    logic [3:0] port_a_mode_ff;
    logic watchdog_on_flag_ff;
    logic first_timer_irq_flag_ff;
    logic second_timer_irq_flag_ff;
    logic pulse_ff;
    logic tout_oe_n_ff;
    logic wdog_req_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic access;
    logic wr;
    logic rd;
    logic [9:0] idx;
    logic word_ok;
    logic mapped;
    logic [3:0] wnib;
    logic evt_rise;
    logic evt_fall;
    logic evt_edge;
    logic t1_tick;
    logic t2_tick;
    logic t1_ovf;
    logic t2_ovf;
    logic [PRESC_BITS-1:0] presc_nxt;
    logic [PRESC_BITS-1:0] presc_rise;
    logic [7:0] nxt_t1_cnt;
    logic [7:0] nxt_t2_cnt;

    // Registered pready answers in the second access cycle; one wait state
    assign access = i_psel && i_penable && !pready_ff;
    assign idx = i_paddr[11:2];
    assign word_ok = (i_paddr[1:0] == 2'b00);
    assign wr = access && i_pwrite && i_pstrb[0] && word_ok;
    assign rd = access && !i_pwrite && word_ok;
    assign wnib = i_pwdata[3:0];
    always_comb begin
        case (idx)
            IDX_IRQ_FLAGS, IDX_PORT_A_MODE, IDX_T1_MODE, IDX_T1_LOAD_LO,
            IDX_T1_LOAD_HI, IDX_T2_MODE, IDX_T2_LOAD_LO, IDX_T2_LOAD_HI,
            IDX_MISC, IDX_PIN_SEL, IDX_EDGE_SEL: mapped = word_ok;
            default: mapped = 1'b0;
        endcase
    end

    // Three-stage pin synchroniser; stage one feeds only stage two
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            evt_sync_ff <= 3'b000;
        end else begin
            evt_sync_ff <= {evt_sync_ff[1:0], i_event_input_pin};
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            evt_level_ff <= 1'b0;
        end else if (evt_sync_ff[1] == evt_sync_ff[2]) begin
            evt_level_ff <= evt_sync_ff[2];
        end
    end
    assign evt_rise = (evt_sync_ff[1] == evt_sync_ff[2])
        && evt_sync_ff[2] && !evt_level_ff;
    assign evt_fall = (evt_sync_ff[1] == evt_sync_ff[2])
        && !evt_sync_ff[2] && evt_level_ff;
    always_comb begin
        case (dtw_edge_type'(first_timer_edge_select_ff))
            EDGE_RISE: evt_edge = evt_rise;
            EDGE_FALL: evt_edge = evt_fall;
            EDGE_BOTH: evt_edge = evt_rise || evt_fall;
            default: evt_edge = 1'b0;
        endcase
    end

    if (PRESC_BITS < PRESC_W) begin : g_presc_chk
        $error("Prescaler narrower than its slowest tap");
    end

    // Shared prescaler; a tick is a rising edge of a chosen tap
    assign presc_nxt = presc_ff + 1'b1;
    assign presc_rise = presc_nxt & ~presc_ff;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= presc_nxt;
        end
    end
    // Divider ladder 2048,512,128,32,8,4,2 then the last entry
    function automatic logic pick_tap(input logic [2:0] sel,
                                      input logic [PRESC_BITS-1:0] r);
        case (sel)
            3'h0: pick_tap = r[10];
            3'h1: pick_tap = r[8];
            3'h2: pick_tap = r[6];
            3'h3: pick_tap = r[4];
            3'h4: pick_tap = r[2];
            3'h5: pick_tap = r[1];
            3'h6: pick_tap = r[0];
            default: pick_tap = 1'b1;
        endcase
    endfunction
    // Event source counts only when the pin is routed to the timer
    assign t1_tick = (t1_mode_ff[2:0] == SRC_EVENT)
        ? (evt_edge && event_pin_select_ff[0])
        : pick_tap(t1_mode_ff[2:0], presc_rise);
    assign t2_tick = pick_tap(second_timer_mode_ff[2:0], presc_rise);
    assign t1_ovf = t1_tick && (first_timer_counter_ff == CNT_MAX);
    assign t2_ovf = t2_tick && (second_timer_counter_ff == CNT_MAX);

    // Configuration registers; write only except the watchdog enable
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            first_timer_edge_select_ff <= EDGE_RST;
            event_pin_select_ff <= NIB_RST;
            t1_mode_ff <= NIB_RST;
            port_a_mode_ff <= NIB_RST;
            tout_oe_n_ff <= 1'b1;
            watchdog_on_flag_ff <= 1'b0;
        end else if (wr) begin
            if (idx == IDX_EDGE_SEL) begin
                first_timer_edge_select_ff <= wnib[1:0];
            end
            if (idx == IDX_PIN_SEL) begin
                event_pin_select_ff <= wnib;
            end
            if (idx == IDX_T1_MODE) begin
                t1_mode_ff <= wnib;
            end
            if (idx == IDX_PORT_A_MODE) begin
                port_a_mode_ff <= wnib;
                tout_oe_n_ff <= !wnib[TOUT_EN_BIT];
            end
            if (idx == IDX_MISC) begin
                watchdog_on_flag_ff <= wnib[WDOG_ON_BIT];
            end
        end
    end

    // Mode write held back so it lands two cycles later
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            second_timer_mode_ff <= NIB_RST;
            t2_mode_pend_ff <= NIB_RST;
            t2_mode_dly_ff <= 2'b00;
        end else if (wr && idx == IDX_T2_MODE) begin
            t2_mode_pend_ff <= wnib;
            t2_mode_dly_ff <= MODE_DELAY_CYC;
        end else if (t2_mode_dly_ff == 2'b01) begin
            second_timer_mode_ff <= t2_mode_pend_ff;
            t2_mode_dly_ff <= 2'b00;
        end else if (t2_mode_dly_ff != 2'b00) begin
            t2_mode_dly_ff <= t2_mode_dly_ff - 2'b01;
        end
    end

    // Load registers; high nibble is left unreset as on the part
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            t1_load_ff.lo <= NIB_RST;
            t2_load_ff.lo <= NIB_RST;
        end else if (wr) begin
            if (idx == IDX_T1_LOAD_LO) begin
                t1_load_ff.lo <= wnib;
            end
            if (idx == IDX_T2_LOAD_LO) begin
                t2_load_ff.lo <= wnib;
            end
            if (idx == IDX_T1_LOAD_HI) begin
                t1_load_ff.hi <= wnib;
            end
            if (idx == IDX_T2_LOAD_HI) begin
                t2_load_ff.hi <= wnib;
            end
        end
    end

    // Counters: high write loads, else count, overflow reloads or zeroes
    always_comb begin
        nxt_t1_cnt = first_timer_counter_ff;
        if (wr && idx == IDX_T1_LOAD_HI) begin
            nxt_t1_cnt = {wnib, t1_load_ff.lo};
        end else if (t1_ovf) begin
            nxt_t1_cnt = t1_mode_ff[MODE_RELOAD_BIT]
                ? t1_load_ff : CNT_ZERO;
        end else if (t1_tick) begin
            nxt_t1_cnt = first_timer_counter_ff + 8'h01;
        end
    end
    always_comb begin
        nxt_t2_cnt = second_timer_counter_ff;
        if (wr && idx == IDX_T2_LOAD_HI) begin
            nxt_t2_cnt = {wnib, t2_load_ff.lo};
        end else if (t2_ovf) begin
            nxt_t2_cnt = second_timer_mode_ff[MODE_RELOAD_BIT]
                ? t2_load_ff : CNT_ZERO;
        end else if (t2_tick) begin
            nxt_t2_cnt = second_timer_counter_ff + 8'h01;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            first_timer_counter_ff <= CNT_ZERO;
            second_timer_counter_ff <= CNT_ZERO;
        end else begin
            first_timer_counter_ff <= nxt_t1_cnt;
            second_timer_counter_ff <= nxt_t2_cnt;
        end
    end

    // High read latches low nibble for a coherent pair
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            t1_latch_ff <= NIB_RST;
            t2_latch_ff <= NIB_RST;
        end else if (rd) begin
            if (idx == IDX_T1_LOAD_HI) begin
                t1_latch_ff <= first_timer_counter_ff[3:0];
            end
            if (idx == IDX_T2_LOAD_HI) begin
                t2_latch_ff <= second_timer_counter_ff[3:0];
            end
        end
    end

    // Sticky flags; an overflow beats a same-cycle clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            first_timer_irq_flag_ff <= 1'b0;
            second_timer_irq_flag_ff <= 1'b0;
        end else begin
            if (t1_ovf) begin
                first_timer_irq_flag_ff <= 1'b1;
            end else if (wr && idx == IDX_IRQ_FLAGS) begin
                first_timer_irq_flag_ff <= wnib[T1_IRQ_BIT];
            end
            if (t2_ovf) begin
                second_timer_irq_flag_ff <= 1'b1;
            end else if (wr && idx == IDX_IRQ_FLAGS) begin
                second_timer_irq_flag_ff <= wnib[T2_IRQ_BIT];
            end
        end
    end

    // One-cycle request; the system reset it causes clears the block
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wdog_req_ff <= 1'b0;
        end else begin
            wdog_req_ff <= t2_ovf && watchdog_on_flag_ff;
        end
    end

    // Pulse: high from overflow until count passes load, low till FF
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pulse_ff <= 1'b0;
        end else if (!port_a_mode_ff[TOUT_EN_BIT]) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= (nxt_t2_cnt <= t2_load_ff);
        end
    end

    // APB read data and answer
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            prdata_ff <= RD_ZERO;
        end else if (rd) begin
            prdata_ff <= RD_ZERO;
            case (idx)
                IDX_T1_LOAD_HI:
                    prdata_ff[3:0] <= first_timer_counter_ff[7:4];
                IDX_T1_LOAD_LO: prdata_ff[3:0] <= t1_latch_ff;
                IDX_T2_LOAD_HI:
                    prdata_ff[3:0] <= second_timer_counter_ff[7:4];
                IDX_T2_LOAD_LO: prdata_ff[3:0] <= t2_latch_ff;
                IDX_IRQ_FLAGS: begin
                    prdata_ff[T1_IRQ_BIT] <= first_timer_irq_flag_ff;
                    prdata_ff[T2_IRQ_BIT] <= second_timer_irq_flag_ff;
                end
                IDX_MISC: prdata_ff[WDOG_ON_BIT] <= watchdog_on_flag_ff;
                default: prdata_ff <= RD_ZERO;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access && !mapped;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_watchdog_reset_req = wdog_req_ff;
    assign o_timer_pulse_output_pin = pulse_ff;
    // Own flop so the pin enable carries no gate after the register
    assign o_timer_pulse_output_oe_n = tout_oe_n_ff;
    assign o_first_timer_irq_flag = first_timer_irq_flag_ff;
    assign o_second_timer_irq_flag = second_timer_irq_flag_ff;
endmodule // dtw_timers
`default_nettype wire

// [tb/dtw_timers_chk.sv]
// Purpose: Port-level assertions for the dual timer block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Sees only the top ports; attached by bind below
`default_nettype none
module dtw_timers_chk
    import dtw_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_event_input_pin,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_watchdog_reset_req,
    input wire logic o_timer_pulse_output_pin,
    input wire logic o_timer_pulse_output_oe_n,
    input wire logic o_first_timer_irq_flag,
    input wire logic o_second_timer_irq_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic acc;
    logic flag_wr;
    assign acc = i_psel && i_penable && !o_pready;
    assign flag_wr = i_psel && i_pwrite && (i_paddr[11:2] == IDX_IRQ_FLAGS);
    chk_ready_after_acc: assert property (acc |=> o_pready)
        else $error("pready missing one cycle after access");
    chk_ready_one_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");
    chk_ready_idle: assert property (!(i_psel && i_penable) |=> !o_pready)
        else $error("pready without an access");
    chk_err_unmapped: assert property (
        acc && i_paddr[11:2] == 10'h3FF |=> o_pslverr && o_pready)
        else $error("unmapped access not flagged");
    chk_mode_reads_zero: assert property (
        o_pready && !i_pwrite && i_paddr[11:2] == IDX_T2_MODE
        |-> o_prdata == RD_ZERO)
        else $error("write-only mode register read not zero");
    chk_flag_one_sticky: assert property (
        o_first_timer_irq_flag && !flag_wr |=> o_first_timer_irq_flag)
        else $error("first flag dropped without a clear");
    chk_flag_two_sticky: assert property (
        o_second_timer_irq_flag && !flag_wr |=> o_second_timer_irq_flag)
        else $error("second flag dropped without a clear");
    chk_wdog_one_cycle: assert property (
        o_watchdog_reset_req |=> !o_watchdog_reset_req)
        else $error("watchdog request longer than one cycle");
    chk_pin_off_disabled: assert property (
        o_timer_pulse_output_oe_n && $past(o_timer_pulse_output_oe_n)
        |-> !o_timer_pulse_output_pin)
        else $error("pulse pin high while not driven");
endmodule // dtw_timers_chk
bind dtw_timers dtw_timers_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .i_event_input_pin(i_event_input_pin), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_watchdog_reset_req(o_watchdog_reset_req),
    .o_timer_pulse_output_pin(o_timer_pulse_output_pin),
    .o_timer_pulse_output_oe_n(o_timer_pulse_output_oe_n),
    .o_first_timer_irq_flag(o_first_timer_irq_flag),
    .o_second_timer_irq_flag(o_second_timer_irq_flag));
`default_nettype wire

// [tb/dtw_timers_test.sv]
// Purpose: Register-level test of the dual timer block over APB
// Assumes: Event pin drives the first timer; second timer on slowest tap, later every clock
// Notes: Slow second-timer check runs early, before the slowest tap first ticks
`default_nettype none
module dtw_timers_test
    import dtw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, penable, pwrite, evp, ready, slverr, wdr, pin, oe_n;
    logic f1, f2, err, saw_req, saw_hi, saw_lo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [3:0] lo_exp [1:3] = '{4'h7, 4'h9, 4'h9};
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    dtw_timers u_dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .i_event_input_pin(evp),
        .o_prdata(prdata), .o_pready(ready), .o_pslverr(slverr),
        .o_watchdog_reset_req(wdr), .o_timer_pulse_output_pin(pin),
        .o_timer_pulse_output_oe_n(oe_n), .o_first_timer_irq_flag(f1),
        .o_second_timer_irq_flag(f2));
    task automatic final_report();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [3:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {28'h0000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [3:0] v);
        apb(1'b1, idx, v);
    endtask
    task automatic rdc(input string nm, input logic [9:0] idx,
                       input logic [3:0] e);
        apb(1'b0, idx, 4'h0);
        check(nm, rd, {28'h0000000, e});
    endtask
    // Long halves so the three-stage synchroniser sees every edge
    task automatic ev();
        evp <= 1'b1;
        repeat (8) @(posedge clk);
        evp <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // By reference so the level is read at the falling edge
    task automatic bit_at_neg(input string nm, ref logic b,
                              input logic e);
        @(negedge clk);
        check(nm, {31'h0, b}, {31'h0, e});
        @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wdr === 1'b1) saw_req <= 1'b1;
        if (cycles == 6000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        {rst, psel, penable, pwrite, evp, saw_req} = 6'b100000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bit_at_neg("oe_n_rst", oe_n, 1'b1);
        bit_at_neg("pin_rst", pin, 1'b0);
        rdc("flags_rst", IDX_IRQ_FLAGS, 4'h0);
        wr(IDX_T2_MODE, 4'h8);
        repeat (3) @(posedge clk);
        wr(IDX_T2_LOAD_LO, 4'h3);
        wr(IDX_T2_LOAD_HI, 4'hC);
        rdc("t2_hi", IDX_T2_LOAD_HI, 4'hC);
        rdc("t2_lo", IDX_T2_LOAD_LO, 4'h3);
        rdc("t2_mode", IDX_T2_MODE, 4'h0);
        apb(1'b0, 10'h3FF, 4'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_rd", rd, 32'h0);
        wr(IDX_T1_MODE, 4'hF);
        repeat (3) @(posedge clk);
        ev();
        rdc("unrouted_hi", IDX_T1_LOAD_HI, 4'h0);
        rdc("unrouted_lo", IDX_T1_LOAD_LO, 4'h0);
        wr(IDX_PIN_SEL, 4'h1);
        wr(IDX_T1_LOAD_HI, 4'hA);
        rdc("hi_only_hi", IDX_T1_LOAD_HI, 4'hA);
        rdc("hi_only_lo", IDX_T1_LOAD_LO, 4'h0);
        wr(IDX_T1_LOAD_LO, 4'h5);
        rdc("lo_store_hi", IDX_T1_LOAD_HI, 4'hA);
        rdc("lo_store_lo", IDX_T1_LOAD_LO, 4'h0);
        wr(IDX_T1_LOAD_HI, 4'h3);
        rdc("retain_hi", IDX_T1_LOAD_HI, 4'h3);
        ev();
        rdc("latched_lo", IDX_T1_LOAD_LO, 4'h5);
        rdc("rise_hi", IDX_T1_LOAD_HI, 4'h3);
        rdc("rise_lo", IDX_T1_LOAD_LO, 4'h6);
        for (int e = 1; e <= 3; e++) begin
            wr(IDX_EDGE_SEL, 4'(e));
            ev();
            rdc("edge_hi", IDX_T1_LOAD_HI, 4'h3);
            rdc("edge_lo", IDX_T1_LOAD_LO, lo_exp[e]);
        end
        wr(IDX_EDGE_SEL, 4'h0);
        wr(IDX_T1_LOAD_LO, 4'hE);
        wr(IDX_T1_LOAD_HI, 4'hF);
        ev();
        bit_at_neg("f1_at_ff", f1, 1'b0);
        ev();
        bit_at_neg("f1_ovf", f1, 1'b1);
        rdc("reload_hi", IDX_T1_LOAD_HI, 4'hF);
        rdc("reload_lo", IDX_T1_LOAD_LO, 4'hE);
        wr(IDX_IRQ_FLAGS, 4'h0);
        bit_at_neg("f1_clr", f1, 1'b0);
        wr(IDX_T1_MODE, 4'h7);
        repeat (3) @(posedge clk);
        wr(IDX_T1_LOAD_LO, 4'hF);
        wr(IDX_T1_LOAD_HI, 4'hF);
        ev();
        rdc("free_hi", IDX_T1_LOAD_HI, 4'h0);
        rdc("free_lo", IDX_T1_LOAD_LO, 4'h0);
        pstrb <= 4'hE;
        wr(IDX_T1_LOAD_HI, 4'h9);
        pstrb <= 4'hF;
        rdc("strb_off_hi", IDX_T1_LOAD_HI, 4'h0);
        wr(IDX_T2_MODE, 4'hF);
        repeat (3) @(posedge clk);
        wr(IDX_T2_LOAD_LO, 4'hE);
        wr(IDX_T2_LOAD_HI, 4'hF);
        repeat (4) @(posedge clk);
        bit_at_neg("f2_ovf", f2, 1'b1);
        rdc("t2_reload_hi", IDX_T2_LOAD_HI, 4'hF);
        check("no_wdog_off", {31'h0, saw_req}, 32'h0);
        wr(IDX_PORT_A_MODE, 4'h4);
        bit_at_neg("oe_n_on", oe_n, 1'b0);
        {saw_hi, saw_lo} = 2'b00;
        repeat (8) begin
            @(negedge clk);
            if (pin === 1'b1) saw_hi = 1'b1;
            if (pin === 1'b0) saw_lo = 1'b1;
        end
        @(posedge clk);
        check("pwm_toggles", {30'h0, saw_hi, saw_lo}, 32'h3);
        wr(IDX_MISC, 4'h2);
        for (int k = 0; k < 20 && saw_req !== 1'b1; k++) @(posedge clk);
        check("wdog_req", {31'h0, saw_req}, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bit_at_neg("f2_after_wdog", f2, 1'b0);
        bit_at_neg("oe_n_after_wdog", oe_n, 1'b1);
        rdc("t2_after_wdog", IDX_T2_LOAD_HI, 4'h0);
        saw_req = 1'b0;
        wr(IDX_MISC, 4'h2);
        repeat (4) wr(IDX_T2_LOAD_HI, 4'h0);
        check("wdog_fed", {31'h0, saw_req}, 32'h0);
        final_report();
    end
endmodule // dtw_timers_test
`default_nettype wire
